//--- four_bit_loadable_up_counter.sv
// four-bit loadable up-counter cell with register port and inline checks
module four_bit_loadable_up_counter
  import four_bit_counter_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // asynchronous controls on the count bits
  input wire logic async_clear,
  input wire logic async_preset,
  // synchronous controls from neighbouring logic
  input wire logic parallel_load_strobe,
  input wire logic [LANES-1:0] count_enable_lane,
  input wire logic [CNT_W-1:0] load_value_bit,
  // count outputs
  output logic [CNT_W-1:0] count_bit_n,
  output logic terminal_count,
  output logic terminal_count_n,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regReadData
);

  // true-sense view of the stored count
  logic [CNT_W-1:0] countValue;
  logic [CNT_W-1:0] nextCount;
  step_t stepKind;
  logic softLoadPending;
  logic [CNT_W-1:0] softLoadValue;
  logic effLoad;
  logic [CNT_W-1:0] effLoadValue;
  logic [WRAP_W-1:0] wrapCount;
  logic next_wrap;
  logic asyncAny;

  assign countValue = ~count_bit_n;
  assign asyncAny = async_clear | async_preset;

  // pin strobe wins over a pending software load
  assign effLoad = parallel_load_strobe | softLoadPending;
  assign effLoadValue = parallel_load_strobe ? load_value_bit : softLoadValue;

  // next-count decision
  count_step stepper (
    .currentCount(countValue),
    .loadStrobe(effLoad),
    .loadValue(effLoadValue),
    .lanes(count_enable_lane),
    .nextCount(nextCount),
    .stepKind(stepKind)
  );

  // decode helpers used by writes and reads
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] reg_off);
    hit = (addr == reg_off);
  endfunction

  // a rollover is a counting edge from all ones
  assign next_wrap = (stepKind == STEP_COUNT) && (countValue == COUNT_ALL_ONES) && !asyncAny;

  // count flops; clear checked first so the undefined both-high case stays clear
  // the inverted bits are stored directly so the outputs come straight off flops
  always_ff @(posedge core_clk or posedge async_clear or posedge async_preset) begin
    if (async_clear) begin
      count_bit_n <= ~COUNT_ZERO;
    end else if (async_preset) begin
      count_bit_n <= ~COUNT_ALL_ONES;
    end else if (sys_rst) begin
      count_bit_n <= ~COUNT_RESET;
    end else begin
      count_bit_n <= ~nextCount;
    end
  end

  // terminal pair is clocked only; async controls steer the value it will take
  // at the edge but never flip it between edges
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      terminal_count <= 1'b0;
      terminal_count_n <= 1'b1;
    end else if (async_clear) begin
      terminal_count <= 1'b0;
      terminal_count_n <= 1'b1;
    end else if (async_preset) begin
      terminal_count <= 1'b1;
      terminal_count_n <= 1'b0;
    end else begin
      terminal_count <= &nextCount;
      terminal_count_n <= ~&nextCount;
    end
  end

  // software load: a write with the go bit arms a load for the next edge only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      softLoadPending <= 1'b0;
      softLoadValue <= COUNT_RESET;
    end else if (regWrite && hit(regAddr, REG_SOFT_LOAD)) begin
      softLoadPending <= regWriteData[SOFT_GO_BIT];
      softLoadValue <= regWriteData[SOFT_VALUE_LSB +: CNT_W];
    end else begin
      softLoadPending <= 1'b0;
    end
  end

  // rollover tally; a rollover in the clearing cycle still counts once
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrapCount <= WRAPS_RESET;
    end else if (regWrite && hit(regAddr, REG_WRAPS)) begin
      wrapCount <= next_wrap ? WRAP_W'(1) : WRAPS_RESET;
    end else if (next_wrap) begin
      wrapCount <= WRAP_W'(wrapCount + 1'b1); // saturating not needed, wraps quietly
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regReadData <= READ_IDLE;
    end else if (!regRead) begin
      regReadData <= READ_IDLE;
    end else if (hit(regAddr, REG_SOFT_LOAD)) begin
      regReadData <= {{(DATA_W-CNT_W){1'b0}}, softLoadValue};
    end else if (hit(regAddr, REG_STATUS)) begin
      regReadData <= READ_IDLE;
      regReadData[STATUS_COUNT_LSB +: CNT_W] <= countValue;
      regReadData[STATUS_TC_BIT] <= terminal_count;
      regReadData[STATUS_LANES_LSB +: LANES] <= count_enable_lane;
      regReadData[STATUS_ASYNC_LSB +: 2] <= {async_preset, async_clear};
    end else if (hit(regAddr, REG_WRAPS)) begin
      regReadData <= {{(DATA_W-WRAP_W){1'b0}}, wrapCount};
    end else begin
      regReadData <= READ_IDLE;
    end
  end

  // checks on the count, the terminal pair and the register port

  // low bits of a write, kept for the software-load check
  logic [CNT_W-1:0] writeValue;
  assign writeValue = regWriteData[SOFT_VALUE_LSB +: CNT_W];

  // a write to the software-load word with the go bit set
  sequence s_softArm;
    regWrite && hit(regAddr, REG_SOFT_LOAD) && regWriteData[SOFT_GO_BIT];
  endsequence

  // a quiet edge: no reset and no async control sampled
  sequence s_quiet;
    !sys_rst && !asyncAny;
  endsequence

  // preset held alone across two edges
  sequence s_presetHeld;
    (async_preset && !async_clear) [*2];
  endsequence

  // clear held alone across two edges
  sequence s_clearHeld;
    (async_clear && !async_preset) [*2];
  endsequence

  property p_load;
    @(posedge core_clk) disable iff (sys_rst || asyncAny)
      parallel_load_strobe |=> (countValue == $past(load_value_bit));
  endproperty
  a_load: assert property (p_load)
    else $error("load strobe did not load the data inputs");

  property p_hold;
    @(posedge core_clk) disable iff (sys_rst || asyncAny)
      (!effLoad && !(&count_enable_lane)) |=> $stable(countValue);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved with an enable lane low");

  property p_count;
    @(posedge core_clk) disable iff (sys_rst || asyncAny)
      (!effLoad && (&count_enable_lane)) |=> (countValue == CNT_W'($past(countValue) + 1'b1));
  endproperty
  a_count: assert property (p_count)
    else $error("count did not advance by one");

  property p_tcMatch;
    @(posedge core_clk) disable iff (sys_rst || asyncAny)
      s_quiet ##1 s_quiet |-> (terminal_count == (countValue == COUNT_ALL_ONES));
  endproperty
  a_tcMatch: assert property (p_tcMatch)
    else $error("terminal count out of step with count");

  property p_tcPair;
    @(posedge core_clk) disable iff (sys_rst)
      $past(!sys_rst) |-> (terminal_count_n == !terminal_count);
  endproperty
  a_tcPair: assert property (p_tcPair)
    else $error("terminal count pair not complementary");

  property p_clearNow;
    @(posedge core_clk) disable iff (sys_rst)
      (async_clear && !async_preset) |-> (count_bit_n == ~COUNT_ZERO);
  endproperty
  a_clearNow: assert property (p_clearNow)
    else $error("async clear did not force zero");

  property p_presetNow;
    @(posedge core_clk) disable iff (sys_rst)
      (async_preset && !async_clear) |-> (count_bit_n == ~COUNT_ALL_ONES);
  endproperty
  a_presetNow: assert property (p_presetNow)
    else $error("async preset did not force all ones");

  property p_presetClocked;
    @(posedge core_clk) disable iff (sys_rst)
      s_presetHeld |-> terminal_count && !terminal_count_n;
  endproperty
  a_presetClocked: assert property (p_presetClocked)
    else $error("terminal count missed preset through clocked path");

  property p_clearClocked;
    @(posedge core_clk) disable iff (sys_rst)
      s_clearHeld |-> !terminal_count && terminal_count_n;
  endproperty
  a_clearClocked: assert property (p_clearClocked)
    else $error("terminal count missed clear through clocked path");

  property p_rollover;
    @(posedge core_clk) disable iff (sys_rst || asyncAny)
      (countValue == COUNT_ALL_ONES && !effLoad && (&count_enable_lane))
        |=> (countValue == COUNT_ZERO) && !terminal_count;
  endproperty
  a_rollover: assert property (p_rollover)
    else $error("rollover from all ones failed");

  property p_readWindow;
    @(posedge core_clk) disable iff (sys_rst)
      !regRead |=> (regReadData == READ_IDLE);
  endproperty
  a_readWindow: assert property (p_readWindow)
    else $error("read data stood outside its cycle");

  // reset leaves the count at zero and the terminal pair idle
  property p_resetState;
    @(posedge core_clk) disable iff (asyncAny)
      sys_rst |=> (count_bit_n == ~COUNT_RESET) && !terminal_count
        && terminal_count_n && (regReadData == READ_IDLE);
  endproperty
  a_resetState: assert property (p_resetState)
    else $error("reset did not clear the count and terminal pair");

  // software load lands one edge after the arming write
  property p_softLoad;
    @(posedge core_clk) disable iff (sys_rst || asyncAny)
      s_softArm ##1 !parallel_load_strobe |=> (countValue == $past(writeValue, 2));
  endproperty
  a_softLoad: assert property (p_softLoad)
    else $error("software load did not land");

  // terminal count keeps its value on a hold edge
  property p_tcHold;
    @(posedge core_clk) disable iff (sys_rst || asyncAny)
      (!effLoad && !(&count_enable_lane)) |=> $stable(terminal_count);
  endproperty
  a_tcHold: assert property (p_tcHold)
    else $error("terminal count moved on a hold edge");

  // first edge of an async control still shows the clocked value, not the forced one
  property p_tcBeforeForce;
    @(posedge core_clk) disable iff (sys_rst)
      (asyncAny && !$past(asyncAny) && !$past(sys_rst))
        |-> (terminal_count == (&($past(nextCount))));
  endproperty
  a_tcBeforeForce: assert property (p_tcBeforeForce)
    else $error("terminal count followed an async control directly");

  // a rollover adds one to the tally
  property p_wrapStep;
    @(posedge core_clk) disable iff (sys_rst || asyncAny)
      (countValue == COUNT_ALL_ONES && !effLoad && (&count_enable_lane)
        && !(regWrite && hit(regAddr, REG_WRAPS)))
        |=> (wrapCount == WRAP_W'($past(wrapCount) + 1'b1));
  endproperty
  a_wrapStep: assert property (p_wrapStep)
    else $error("rollover tally did not advance");

  // a write to the tally clears it unless a rollover meets it
  property p_wrapClear;
    @(posedge core_clk) disable iff (sys_rst)
      (regWrite && hit(regAddr, REG_WRAPS)
        && !(countValue == COUNT_ALL_ONES && !effLoad && (&count_enable_lane)))
        |=> (wrapCount == WRAPS_RESET);
  endproperty
  a_wrapClear: assert property (p_wrapClear)
    else $error("rollover tally not cleared by write");

  // status read returns the count and terminal flag of the strobe cycle
  property p_readStatus;
    @(posedge core_clk) disable iff (sys_rst)
      (regRead && hit(regAddr, REG_STATUS))
        |=> (regReadData[STATUS_COUNT_LSB +: CNT_W] == $past(countValue))
          && (regReadData[STATUS_TC_BIT] == $past(terminal_count));
  endproperty
  a_readStatus: assert property (p_readStatus)
    else $error("status read does not match the count");

  // tally read returns the tally of the strobe cycle
  property p_readWraps;
    @(posedge core_clk) disable iff (sys_rst)
      (regRead && hit(regAddr, REG_WRAPS))
        |=> (regReadData[WRAPS_LSB +: WRAP_W] == $past(wrapCount));
  endproperty
  a_readWraps: assert property (p_readWraps)
    else $error("tally read does not match the tally");

endmodule // four_bit_loadable_up_counter

//--- four_bit_counter_pkg.sv
// constants, register map and field layout for the four-bit loadable up-counter
// How it works
// - holds a four-bit up-count, clocked on rising edge, shown on active-low outputs.
// - terminal count and complement are clocked, in phase with the count outputs.
// - async clear forces zero, async preset forces all ones; both together undefined.
// - async preset and clear reach terminal count only through its clocked path.
// - load strobe loads regardless of lanes; any low lane holds; all high counts.
package four_bit_counter_pkg;

  // datapath widths
  localparam int CNT_W = 4;
  localparam int LANES = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WRAP_W = 16;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_SOFT_LOAD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_WRAPS = 8'h08;

  // field positions
  localparam int SOFT_VALUE_LSB = 0;
  localparam int SOFT_GO_BIT = 4;
  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_TC_BIT = 4;
  localparam int STATUS_LANES_LSB = 8;
  localparam int STATUS_ASYNC_LSB = 12;
  localparam int WRAPS_LSB = 0;

  // values after reset and forced values
  localparam logic [CNT_W-1:0] COUNT_RESET = 4'h0;
  localparam logic [CNT_W-1:0] COUNT_ALL_ONES = 4'hF;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 4'h0;
  localparam logic [WRAP_W-1:0] WRAPS_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

  // what one clock edge does to the count
  typedef enum {STEP_LOAD, STEP_HOLD, STEP_COUNT} step_t;

endpackage

//--- count_step.sv
// next-count decision for one clock edge: load, hold or increment
module count_step
  import four_bit_counter_pkg::*;
(
  // present state
  input wire logic [CNT_W-1:0] currentCount,
  // controls
  input wire logic loadStrobe,
  input wire logic [CNT_W-1:0] loadValue,
  input wire logic [LANES-1:0] lanes,
  // result
  output logic [CNT_W-1:0] nextCount,
  output step_t stepKind
);

  always_comb begin
    if (loadStrobe) begin
      stepKind = STEP_LOAD;
      nextCount = loadValue;
    end else if (&lanes) begin
      stepKind = STEP_COUNT;
      nextCount = CNT_W'(currentCount + 1'b1); // wraps 15 to 0
    end else begin
      stepKind = STEP_HOLD;
      nextCount = currentCount;
    end
  end

endmodule // count_step

//--- lower_cell_model.sv
// lower chained counter cell that feeds one enable lane of the cell under test
module lower_cell_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // controls from the bench
  input wire logic lowLoad,
  input wire logic [3:0] lowValue,
  input wire logic lowRun,
  // chain output
  output logic lowTc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lowCount;
  // plain up-count, so the upper cell sees a real carry every sixteen edges
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lowCount <= 4'h0;
    end else if (lowLoad) begin
      lowCount <= lowValue;
    end else if (lowRun) begin
      lowCount <= lowCount + 4'h1;
    end
  end
  assign lowTc = (lowCount == 4'hF);
endmodule // lower_cell_model

//--- testbench.sv
// self-checking bench for the four-bit loadable up-counter cell
module testbench
  import four_bit_counter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic asyncClear = 1'b0;
  logic asyncPreset = 1'b0;
  logic loadStrobe = 1'b0;
  logic [3:0] loadValue = 4'h0;
  logic [2:0] laneHi = 3'h7;
  logic lowLoad = 1'b0;
  logic [3:0] lowValue = 4'h0;
  logic lowRun = 1'b0;
  logic lowTc;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWriteData = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regReadData;
  logic [3:0] countBitN;
  logic termCount;
  logic termCountN;
  logic [31:0] rdata;
  logic [3:0] e;
  int fail_count = 0;
  int checks_done = 0;
  // clock, 8 ns period
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  lower_cell_model i_lower_cell_model (.core_clk(core_clk), .sys_rst(sys_rst),
    .lowLoad(lowLoad), .lowValue(lowValue), .lowRun(lowRun), .lowTc(lowTc));
  four_bit_loadable_up_counter i_four_bit_loadable_up_counter (.core_clk(core_clk),
    .sys_rst(sys_rst), .async_clear(asyncClear), .async_preset(asyncPreset),
    .parallel_load_strobe(loadStrobe), .count_enable_lane({laneHi, lowTc}),
    .load_value_bit(loadValue), .count_bit_n(countBitN), .terminal_count(termCount),
    .terminal_count_n(termCountN), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // count outputs are inverted, terminal pair must be complementary
  task automatic out(input logic [3:0] cnt, input logic tc);
    #1;
    cmp({28'h0, countBitN}, {28'h0, ~cnt});
    cmp({30'h0, termCount, termCountN}, {30'h0, tc, ~tc});
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence; laneHi is high except during the load and hold-lane checks
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    out(4'h0, 1'b0);
    @(posedge core_clk);
    lowLoad <= 1'b1;
    lowValue <= 4'hF;
    loadStrobe <= 1'b1;
    loadValue <= 4'hE;
    laneHi <= 3'h0;
    @(posedge core_clk);
    lowLoad <= 1'b0;
    loadStrobe <= 1'b0;
    out(4'hE, 1'b0);
    @(posedge core_clk);
    laneHi <= 3'h7;
    @(posedge core_clk);
    out(4'hF, 1'b1);
    @(posedge core_clk);
    out(4'h0, 1'b0);
    e = 4'h0;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      laneHi <= ~(3'h1 << i);
      if (i == 0) e = 4'h1;
      @(posedge core_clk);
      out(e, 1'b0);
    end
    @(posedge core_clk);
    laneHi <= 3'h7;
    lowLoad <= 1'b1;
    lowValue <= 4'h0;
    @(posedge core_clk);
    lowLoad <= 1'b0;
    @(posedge core_clk);
    out(4'h2, 1'b0);
    @(posedge core_clk);
    asyncPreset <= 1'b1;
    out(4'hF, 1'b0);
    @(posedge core_clk);
    out(4'hF, 1'b1);
    @(posedge core_clk);
    asyncPreset <= 1'b0;
    asyncClear <= 1'b1;
    out(4'h0, 1'b1);
    // clear held across two edges so the clocked pair follows it
    @(posedge core_clk);
    out(4'h0, 1'b0);
    @(posedge core_clk);
    asyncClear <= 1'b0;
    out(4'h0, 1'b0);
    rd(REG_STATUS, rdata);
    cmp(rdata, 32'h0000_0E00);
    rd(REG_WRAPS, rdata);
    cmp(rdata, 32'h0000_0001);
    wr(REG_WRAPS, 32'h0000_0000);
    rd(REG_WRAPS, rdata);
    cmp(rdata, 32'h0000_0000);
    rd(8'h0C, rdata);
    cmp(rdata, 32'h0000_0000);
    wr(REG_SOFT_LOAD, 32'h0000_0019);
    @(posedge core_clk);
    out(4'h9, 1'b0);
    // lower cell carries twice in 32 edges, upper advances by two
    @(posedge core_clk);
    lowRun <= 1'b1;
    repeat (32) @(posedge core_clk);
    lowRun <= 1'b0;
    out(4'hB, 1'b0);
    // value stored without the go bit leaves the count alone
    wr(REG_SOFT_LOAD, 32'h0000_0005);
    rd(REG_SOFT_LOAD, rdata);
    cmp(rdata, 32'h0000_0005);
    out(4'hB, 1'b0);
    // a pin load at the edge of a pending software load wins
    wr(REG_SOFT_LOAD, 32'h0000_0013);
    loadStrobe <= 1'b1;
    loadValue <= 4'h6;
    @(posedge core_clk);
    loadStrobe <= 1'b0;
    out(4'h6, 1'b0);
    @(posedge core_clk);
    out(4'h6, 1'b0);
    // reset in mid-run, then a load on the first edge after release
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    loadStrobe <= 1'b1;
    loadValue <= 4'hC;
    out(4'h0, 1'b0);
    @(posedge core_clk);
    loadStrobe <= 1'b0;
    out(4'hC, 1'b0);
    rd(REG_SOFT_LOAD, rdata);
    cmp(rdata, 32'h0000_0000);
    summarize();
  end
endmodule // testbench
